// [logic/scr_host.sv]
/*
  Host controller for a self-clocked serial converter: raises the
  conversion trigger, waits the MSB-ready time, bursts 18 serial clock
  pulses and captures the header and 16-bit result on three phases.
  Assumes the converter data line is asynchronous to ref_clk_i.
*/
// Notes on behaviour
// - Host samples data on three phases spaced 90 degrees apart.
// - Host picks the phase whose capture holds the header one correctly.
// - Host drops the trigger before the maximum trigger-high time.
// - Host starts the clock burst only after MSB-ready time.
// - Host gives exactly 18 clock pulses per result before the deadline.
// - Host holds the serial clock high between bursts.
// - First result after power-up is discarded; cycle time must stay bounded.
// - Each converter gets its own alignment capture machine.
`default_nettype none
module scr_host
  import scr_pkg::*;
#(
  parameter int MSB_WAIT = MSB_READY_CYC
)
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // User request
  input  wire logic                 start_i,
  output logic                      busy_o,
  // Converter pins
  output scr_pkg::scr_pins_type     pins_o,
  input  wire logic                 data_i,
  // Result
  output scr_pkg::scr_result_type   result_o
);
  import scr_pkg::*;

  // ---------------------------------------------------------------
  // Data line synchroniser
  // ---------------------------------------------------------------
  logic data_meta;
  logic data_sync;

  // Two flops before any logic reads the pin
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end
    else
    begin
      data_meta <= data_i;
      data_sync <= data_meta;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  scr_state_type state;
  scr_state_type next_state;
  logic [7:0]    count;
  logic [7:0]    next_count;
  logic [4:0]    pulses;
  logic [4:0]    next_pulses;
  logic [1:0]    sub;
  logic [1:0]    next_sub;
  logic          sclk;
  logic          next_sclk;
  logic          trigger;
  logic          next_trigger;
  logic          first_seen;
  logic          next_first_seen;
  logic [2:0]    phase_stb;
  logic          cap_start;
  logic          cap_finish;
  scr_result_type cap_result;

  // Next state of the sequencer
  always_comb
  begin
    next_state      = state;
    next_count      = count;
    next_pulses     = pulses;
    next_sub        = sub;
    next_sclk       = sclk;
    next_trigger    = trigger;
    next_first_seen = first_seen;
    phase_stb       = '0;
    cap_start       = 1'b0;
    cap_finish      = 1'b0;
    case (state)
      SCR_IDLE:
      begin
        next_sclk = 1'b1;
        if (start_i)
        begin
          next_trigger = 1'b1;
          next_count   = 8'(TRIGGER_HIGH_CYC - 1);
          cap_start    = 1'b1;
          next_state   = SCR_TRIG;
        end
      end
      SCR_TRIG:
      begin
        if (count == 8'h00)
        begin
          next_trigger = 1'b0;
          next_count   = 8'(MSB_WAIT);
          next_state   = SCR_WAIT;
        end
        else
          next_count = count - 8'h01;
      end
      SCR_WAIT:
      begin
        if (count == 8'h00)
        begin
          next_pulses = '0;
          next_sub    = '0;
          next_state  = SCR_BURST;
        end
        else
          next_count = count - 8'h01;
      end
      SCR_BURST:
      begin
        // Four host cycles per serial period: low, low, high, high
        next_sub = sub + 2'h1;
        if (sub == 2'h0)
          next_sclk = 1'b0;
        if (sub == 2'h2)
          next_sclk = 1'b1;
        // Three sample points across the period
        phase_stb[0] = (sub == 2'h1);
        phase_stb[1] = (sub == 2'h2);
        phase_stb[2] = (sub == 2'h3);
        if (sub == 2'h3)
        begin
          next_pulses = pulses + 5'h01;
          if (pulses == 5'(BURST_PULSES - 1))
            next_state = SCR_DONE;
        end
      end
      SCR_DONE:
      begin
        next_sclk       = 1'b1;
        cap_finish      = 1'b1;
        next_state      = SCR_IDLE;
      end
      default:
        next_state = SCR_IDLE;
    endcase
    // Arm only after the first captured word has gone by unflagged
    if (cap_result.valid)
      next_first_seen = 1'b1;
  end

  // Register the sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state      <= SCR_IDLE;
      count      <= '0;
      pulses     <= '0;
      sub        <= '0;
      sclk       <= 1'b1;
      trigger    <= 1'b0;
      first_seen <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      count      <= next_count;
      pulses     <= next_pulses;
      sub        <= next_sub;
      sclk       <= next_sclk;
      trigger    <= next_trigger;
      first_seen <= next_first_seen;
    end
  end

  // ---------------------------------------------------------------
  // Capture, one instance per converter
  // ---------------------------------------------------------------
  scr_phase_capture u_cap
  (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .start_i     (cap_start),
    .phase_stb_i (phase_stb),
    .finish_i    (cap_finish),
    .data_i      (data_sync),
    .result_o    (cap_result)
  );

  // Outputs; the first result after power-up is never flagged valid
  always_comb
  begin
    result_o       = cap_result;
    result_o.valid = cap_result.valid & first_seen;
  end

  assign pins_o         = '{sclk: sclk, trigger: trigger};
  assign busy_o         = (state != SCR_IDLE);
endmodule
`default_nettype wire

// [logic/scr_pkg.sv]
/*
  Package for the self-clocked converter readout host: timing constants,
  state encodings and the carrier structs shared by the host files.
  Assumes a 20 MHz host clock; times are in nanoseconds.
*/
`default_nettype none
package scr_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS         = 50;
  localparam int TRIGGER_HIGH_NS       = 100;   // Kept below trigger_high_max
  localparam int MSB_READY_NS          = 200;   // msb_ready_time, least wait
  localparam int TRIGGER_HIGH_CYC      = (TRIGGER_HIGH_NS / CLK_PERIOD_NS) < 1 ? 1
                                         : TRIGGER_HIGH_NS / CLK_PERIOD_NS;
  localparam int MSB_READY_CYC         = (MSB_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC         = 2;     // Serial clock half period
  localparam int BURST_PULSES          = 18;
  localparam int HEADER_BITS           = 3;
  localparam int RESULT_BITS           = 16;
  localparam int PHASES                = 3;
  localparam logic [2:0] HEADER_CODE   = 3'h2;  // 010
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0]
  {
    SCR_IDLE  = 5'b0_0001,
    SCR_TRIG  = 5'b0_0010,
    SCR_WAIT  = 5'b0_0100,
    SCR_BURST = 5'b0_1000,
    SCR_DONE  = 5'b1_0000
  } scr_state_type;

  typedef struct packed
  {
    logic        valid;
    logic [15:0] data;
    logic [1:0]  phase;
    logic        header_ok;
  } scr_result_type;

  typedef struct packed
  {
    logic sclk;
    logic trigger;
  } scr_pins_type;
endpackage
`default_nettype wire

// [logic/scr_phase_capture.sv]
/*
  Per-converter alignment capture: samples the data line on three
  phases of the serial clock, finds the header one and assembles
  the result word from the phase that lands inside the valid window.
  Assumes data_i is already synchronised to ref_clk_i and that the
  phase strobes come from the burst generator in the same domain.
*/
`default_nettype none
module scr_phase_capture
  import scr_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // Control from the burst generator and the synchronised data line
  input  wire logic                 start_i,
  input  wire logic [2:0]           phase_stb_i,
  input  wire logic                 finish_i,
  input  wire logic                 data_i,
  // Result
  output scr_pkg::scr_result_type   result_o
);
  import scr_pkg::*;

  localparam int SHW = HEADER_BITS + RESULT_BITS;

  logic [SHW-1:0] shift [PHASES];
  logic [SHW-1:0] next_shift [PHASES];
  scr_result_type result;
  scr_result_type next_result;

  // Pick the phase whose capture shows the full 010 header
  function automatic logic [1:0] pick_phase(input logic [2:0] ok);
    if (ok[1])
      pick_phase = 2'h1;
    else if (ok[0])
      pick_phase = 2'h0;
    else
      pick_phase = 2'h2;
  endfunction

  // ---------------------------------------------------------------
  // Shift registers, one per phase
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : g_ph
      // Next shift value for this phase
      always_comb
      begin
        next_shift[g] = shift[g];
        if (start_i)
          next_shift[g] = '0;
        else if (phase_stb_i[g])
          next_shift[g] = {shift[g][SHW-2:0], data_i};
      end
      // Register the shift value
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          shift[g] <= '0;
        else
          shift[g] <= next_shift[g];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Phase selection and word assembly
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [2:0] ok;
    logic [1:0] sel;
    ok = '0;
    sel = '0;
    next_result = result;
    next_result.valid = 1'b0;
    for (int p = 0; p < PHASES; p++)
      ok[p] = (shift[p][SHW-1 -: HEADER_BITS] == HEADER_CODE);
    sel = pick_phase(ok);
    if (finish_i)
    begin
      next_result.valid     = 1'b1;
      next_result.phase     = sel;
      next_result.header_ok = |ok;
      next_result.data      = shift[sel][RESULT_BITS-1:0];
    end
  end

  // Register the result
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      result <= '0;
    else
      result <= next_result;
  end

  assign result_o = result;
endmodule
`default_nettype wire

// [verif/scr_host_sva.sv]
/* Port checker for scr_host.
   Assumes one clock domain and a bind onto scr_host. */
`default_nettype none
module scr_host_sva
  import scr_pkg::*;
#(
  parameter int MSB_WAIT = MSB_READY_CYC
)
(
  // Clock and reset
  input wire logic           ref_clk_i,
  input wire logic           rst_n_i,
  // Watched ports
  input wire logic           start_i,
  input wire logic           busy_o,
  input wire scr_pins_type   pins_o,
  input wire logic           data_i,
  input wire scr_result_type result_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       trig_q;
  logic       sclk_q;
  logic [4:0] since;
  logic [4:0] falls;
  logic [4:0] next_since;
  logic [4:0] next_falls;
  // Cycles since trigger rise and serial clock falls per burst
  always_comb
  begin
    next_since = (since == 5'h1F) ? since : since + 5'h01;
    next_falls = (sclk_q && !pins_o.sclk) ? falls + 5'h01 : falls;
    if (pins_o.trigger && !trig_q)
    begin
      next_since = 5'h00;
      next_falls = 5'h00;
    end
  end
  // Helper registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trig_q <= 1'b0;
      sclk_q <= 1'b1;
      since  <= 5'h00;
      falls  <= 5'h00;
    end
    else
    begin
      trig_q <= pins_o.trigger;
      sclk_q <= pins_o.sclk;
      since  <= next_since;
      falls  <= next_falls;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence trig_pulse_s;
    pins_o.trigger [*2] ##1 !pins_o.trigger;
  endsequence
  sequence clk_pulse_s;
    !pins_o.sclk [*2] ##1 pins_o.sclk [*2];
  endsequence
  chk_trig_width: assert property ($rose(pins_o.trigger) |-> trig_pulse_s)
    else $error("trigger pulse width wrong");
  chk_clk_shape: assert property ($fell(pins_o.sclk) |-> clk_pulse_s)
    else $error("serial clock pulse shape wrong");
  chk_pulse_count: assert property ($fell(busy_o) |-> falls == 5'h12)
    else $error("burst pulse count wrong");
  chk_msb_wait: assert property ($fell(pins_o.sclk) && falls == 5'h00 |-> since >= MSB_WAIT)
    else $error("burst began too early");
  chk_idle_high: assert property (!busy_o |-> pins_o.sclk)
    else $error("serial clock not high at idle");
  chk_take_start: assert property (start_i && !busy_o |=> busy_o && pins_o.trigger)
    else $error("start not taken");
  chk_trig_rest: assert property ($rose(pins_o.trigger) |-> !$past(busy_o))
    else $error("trigger raised while busy");
  chk_gate_clock: assert property (pins_o.trigger |-> pins_o.sclk)
    else $error("clock runs during trigger");
  chk_valid_once: assert property (result_o.valid |=> !result_o.valid)
    else $error("valid longer than one cycle");
endmodule
bind scr_host scr_host_sva #(.MSB_WAIT(MSB_WAIT)) u_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .start_i(start_i), .busy_o(busy_o), .pins_o(pins_o), .data_i(data_i), .result_o(result_o));
`default_nettype wire

// [verif/scr_adc_model.sv]
/* Behavioural converter on the far side of scr_host.
   Assumes trigger and serial clock come from the host. */
`default_nettype none
module scr_adc_model
  import scr_pkg::*;
(
  // Host pins
  input wire logic        trigger_i,
  input wire logic        sclk_i,
  // Bench controls
  input wire logic [15:0] sample_i,
  input var int           skew_ns_i,
  // Serial data
  output var logic        data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [18:0] word;
  int          idx = -1;
  initial data_o = 1'b1;
  // Conversion; triggers during the wait are missed by the busy process
  always @(posedge trigger_i)
  begin
    #(MSB_READY_NS);
    word = {HEADER_CODE, sample_i};
    idx = 18;
    data_o <= #(skew_ns_i) word[18];
  end
  // One bit per falling clock edge
  always @(negedge sclk_i)
  begin
    if (idx > 0)
    begin
      idx = idx - 1;
      data_o <= #(skew_ns_i) word[idx];
    end
  end
  // Line driven to the inverse of the last bit 100 ns after the burst
  always @(posedge sclk_i)
  begin
    if (idx == 0)
    begin
      idx = -1;
      data_o <= #(100) ~word[0];
    end
  end
endmodule
`default_nettype wire

// [verif/scr_host_tb.sv]
/* Self-checking bench for scr_host.
   Assumes scr_adc_model on the pins and the bound checker. */
`default_nettype none
module scr_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import scr_pkg::*;
  logic           ref_clk_i = 1'b0;
  logic           rst_n_i = 1'b0;
  logic           start_i = 1'b0;
  logic           busy;
  logic           line;
  logic           seen;
  logic [15:0]    sample = 16'h0000;
  logic [18:0]    e;
  scr_pins_type   pins;
  scr_result_type result;
  int             skew = 0;
  int             num_errors = 0;
  int             comparisons = 0;
  int             trig_rises;
  int             sclk_falls;
  logic [15:0]    corner [4] = '{16'h0000, 16'hFFFF, 16'h8001, 16'h7FFE};
  scr_host dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .busy_o(busy),
    .pins_o(pins), .data_i(line), .result_o(result));
  scr_adc_model adc (.trigger_i(pins.trigger), .sclk_i(pins.sclk), .sample_i(sample),
    .skew_ns_i(skew), .data_o(line));
  // Clock and pin event counters
  initial forever #25 ref_clk_i = ~ref_clk_i;
  always @(posedge pins.trigger) trig_rises++;
  always @(negedge pins.sclk) sclk_falls++;
  function automatic logic [18:0] exp_serial(input logic [15:0] v);
    return {HEADER_CODE, v};
  endfunction
  // Skew up to half a host cycle: only the last sample point clears the sync flops
  function automatic logic [1:0] exp_phase(input int sk);
    return (sk < 25) ? 2'h2 : 2'h2;
  endfunction
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_count(input int got, input int exp);
    cmp_word(got[15:0], exp[15:0]);
  endtask
  // One request; start may be held to test refusal while busy
  task automatic convert(input logic [15:0] v, input logic hold);
    @(negedge ref_clk_i);
    sample = v;
    trig_rises = 0;
    sclk_falls = 0;
    start_i = 1'b1;
    seen = 1'b0;
    for (int n = 0; n < 200 && !seen; n++)
    begin
      @(negedge ref_clk_i);
      start_i = hold && (sclk_falls == 0);
      seen = (result.valid === 1'b1);
    end
    for (int n = 0; n < 20 && busy !== 1'b0; n++)
      @(negedge ref_clk_i);
  endtask
  // Watchdog
  initial
  begin
    #(5000 * 50);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h0450));
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    convert(16'h1234, 1'b0);
    cmp_word({15'h0000, seen}, 16'h0000);
    for (int i = 0; i < 12; i++)
    begin
      skew = 25 * $urandom_range(1, 0);
      e = exp_serial((i < 4) ? corner[i] : 16'($urandom));
      convert(e[15:0], i[0]);
      cmp_word({15'h0000, seen}, 16'h0001);
      cmp_word(result.data, e[15:0]);
      cmp_word({15'h0000, result.header_ok}, 16'h0001);
      cmp_word({14'h0000, result.phase}, {14'h0000, exp_phase(skew)});
      cmp_count(trig_rises, 1);
      cmp_count(sclk_falls, BURST_PULSES);
    end
    // Reset in mid-burst, then the first result is dropped again
    @(negedge ref_clk_i);
    start_i = 1'b1;
    repeat (20) @(negedge ref_clk_i);
    start_i = 1'b0;
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    cmp_word({14'h0000, pins.sclk, pins.trigger}, 16'h0002);
    rst_n_i = 1'b1;
    convert(16'hA5C3, 1'b0);
    cmp_word({15'h0000, seen}, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
